// file: src/cocr_map.vh
`ifndef COCR_MAP_VH
`define COCR_MAP_VH

// Direct register offsets.
`define COCR_FMT_CFG_OFS     8'h6b
`define COCR_IND_ADDR_OFS    8'h6c
`define COCR_IND_DATA_OFS    8'h6d

// Format configuration fields.
`define COCR_OUTPUT_FORMAT_SELECT_MSB        7
`define COCR_OUTPUT_FORMAT_SELECT_LSB        4
`define COCR_INPUT_FORMAT_SELECT_MSB        3
`define COCR_INPUT_FORMAT_SELECT_LSB        2
`define COCR_VS_INV_BIT      1
`define COCR_AV_INV_BIT      0
`define COCR_OUTPUT_FORMAT_SELECT_MAX        4'h9

// Indirect register offsets.
`define COCR_I_CLK_PREP      8'h00
`define COCR_I_CLK_ZERO      8'h01
`define COCR_I_CLK_TRAIL     8'h02
`define COCR_I_CLK_POST      8'h03
`define COCR_I_HS_PREP       8'h04
`define COCR_I_HS_ZERO       8'h05
`define COCR_I_HS_TRAIL      8'h06
`define COCR_I_HS_EXIT       8'h07
`define COCR_I_LP_PERIOD     8'h08
`define COCR_I_RAW_ALIGN     8'h09
`define COCR_I_PORT0_EN      8'h13
`define COCR_I_PORT1_EN      8'h14
`define COCR_I_PASSTHRU      8'h16
`define COCR_I_VC_ID         8'h2e

// Timing override fields.
`define COCR_OVR_BIT         7
`define COCR_CLK_PREP_MSB    4
`define COCR_CLK_ZERO_MSB    5

// Reset values.
`define COCR_RST_VAL         8'h00

`endif

// file: src/cocr_ind_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "cocr_map.vh"

// Indirect register space; undefined offsets read zero and ignore writes.
module cocr_ind_regs (
   // Clock and reset
   input  wire        core_clk,
   input  wire        rstn,
   // Access port
   input  wire [7:0]  ind_addr,
   input  wire        ind_wr,
   input  wire [7:0]  ind_wdata,
   output wire [7:0]  ind_rdata,
   // Decoded contents
   output wire [111:0] ind_flat
);

   localparam NREG = 14;

   reg [7:0] mem_reg [0:NREG-1];

   function [4:0] slot_of;
      input [7:0] a;
      begin
         case (a)
            `COCR_I_CLK_PREP:  slot_of = 5'h00;
            `COCR_I_CLK_ZERO:  slot_of = 5'h01;
            `COCR_I_CLK_TRAIL: slot_of = 5'h02;
            `COCR_I_CLK_POST:  slot_of = 5'h03;
            `COCR_I_HS_PREP:   slot_of = 5'h04;
            `COCR_I_HS_ZERO:   slot_of = 5'h05;
            `COCR_I_HS_TRAIL:  slot_of = 5'h06;
            `COCR_I_HS_EXIT:   slot_of = 5'h07;
            `COCR_I_LP_PERIOD: slot_of = 5'h08;
            `COCR_I_RAW_ALIGN: slot_of = 5'h09;
            `COCR_I_PORT0_EN:  slot_of = 5'h0a;
            `COCR_I_PORT1_EN:  slot_of = 5'h0b;
            `COCR_I_PASSTHRU:  slot_of = 5'h0c;
            `COCR_I_VC_ID:     slot_of = 5'h0d;
            default:           slot_of = 5'h1f;
         endcase
      end
   endfunction

   wire [4:0] slot = slot_of(ind_addr);
   wire       hit  = (slot != 5'h1f);

   integer i;
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (i = 0; i < NREG; i = i + 1)
            mem_reg[i] <= `COCR_RST_VAL;
      end else if (ind_wr && hit) begin
         mem_reg[slot[3:0]] <= ind_wdata;
      end
   end

   assign ind_rdata = hit ? mem_reg[slot[3:0]] : 8'h00;

   genvar g;
   generate
      for (g = 0; g < NREG; g = g + 1) begin : flat_g
         assign ind_flat[g*8 +: 8] = mem_reg[g];
      end
   endgenerate

endmodule
`default_nettype wire

// file: src/cocr_csi_cfg.v
`timescale 1ns/1ps
`default_nettype none
`include "cocr_map.vh"

module cocr_csi_cfg #(
   parameter [4:0] AUTO_CLK_PREP = 5'h06,
   parameter [5:0] AUTO_CLK_ZERO = 6'h14
) (
   // Clock and reset
   input  wire        core_clk,
   input  wire        rstn,
   // Register access port
   input  wire [7:0]  reg_addr,
   input  wire        reg_wr,
   input  wire        reg_rd,
   input  wire [7:0]  reg_wdata,
   output reg  [7:0]  reg_rdata,
   output wire        reg_hit,
   // Video flags from the link receiver
   input  wire        vertical_sync_in,
   input  wire        active_video_flag_in,
   // Video flags to the CSI-2 logic
   output reg         vertical_sync,
   output reg         active_video_flag,
   // Format configuration
   output wire [3:0]  output_format_select,
   output wire [1:0]  input_format_select,
   output wire        output_format_valid,
   // Lane timing and port setup
   output reg  [4:0]  clock_prepare_value,
   output reg  [5:0]  clock_zero_value,
   output wire        clock_prepare_override,
   output wire        clock_zero_override,
   output wire [7:0]  clock_trail_time,
   output wire [7:0]  clock_post_time,
   output wire [7:0]  hs_prepare_time,
   output wire [7:0]  hs_zero_time,
   output wire [7:0]  hs_trail_time,
   output wire [7:0]  hs_exit_time,
   output wire [7:0]  lp_period_time,
   output wire [7:0]  raw_alignment,
   output wire [7:0]  output_port0_enable,
   output wire [7:0]  output_port1_enable,
   output wire [7:0]  passthrough_control_field,
   output wire [7:0]  virtual_channel_identifier
);

   // Slot of each indirect register on the flattened storage bus.
   localparam [3:0] SLOT_CLK_PREP  = 4'h0;
   localparam [3:0] SLOT_CLK_ZERO  = 4'h1;
   localparam [3:0] SLOT_CLK_TRAIL = 4'h2;
   localparam [3:0] SLOT_CLK_POST  = 4'h3;
   localparam [3:0] SLOT_HS_PREP   = 4'h4;
   localparam [3:0] SLOT_HS_ZERO   = 4'h5;
   localparam [3:0] SLOT_HS_TRAIL  = 4'h6;
   localparam [3:0] SLOT_HS_EXIT   = 4'h7;
   localparam [3:0] SLOT_LP_PERIOD = 4'h8;
   localparam [3:0] SLOT_RAW_ALIGN = 4'h9;
   localparam [3:0] SLOT_PORT0_EN  = 4'ha;
   localparam [3:0] SLOT_PORT1_EN  = 4'hb;
   localparam [3:0] SLOT_PASSTHRU  = 4'hc;
   localparam [3:0] SLOT_VC_ID     = 4'hd;

   // One-hot codes of the direct registers; all zero is a miss.
   localparam [2:0] DSEL_NONE = 3'b000;
   localparam [2:0] DSEL_FMT  = 3'b001;
   localparam [2:0] DSEL_IA   = 3'b010;
   localparam [2:0] DSEL_ID   = 3'b100;

   reg  [7:0]   format_config_reg;
   reg  [7:0]   format_config_next;
   reg  [7:0]   indirect_address_reg;
   reg  [7:0]   indirect_address_next;
   reg  [7:0]   rdata_next;
   reg          vs_meta_reg;
   reg          vs_sync_reg;
   reg          av_meta_reg;
   reg          av_sync_reg;
   reg          vs_next;
   reg          av_next;
   reg  [4:0]   clock_prepare_next;
   reg  [5:0]   clock_zero_next;
   wire [2:0]   dir_sel;
   wire         ind_wr;
   wire [7:0]   ind_rdata;
   wire [111:0] ind_flat;
   wire [7:0]   clk_prep_raw;
   wire [7:0]   clk_zero_raw;

   // Decodes a direct register address into its one-hot select.
   function [2:0] direct_select;
      input [7:0] addr;
      begin
         case (addr)
            `COCR_FMT_CFG_OFS:  direct_select = DSEL_FMT;
            `COCR_IND_ADDR_OFS: direct_select = DSEL_IA;
            `COCR_IND_DATA_OFS: direct_select = DSEL_ID;
            default:            direct_select = DSEL_NONE;
         endcase
      end
   endfunction

   // Picks one stored indirect register out of the flattened bus.
   function [7:0] ind_byte;
      input [111:0] flat;
      input [3:0]   slot;
      begin
         ind_byte = flat[slot*8 +: 8];
      end
   endfunction

   // Applies the programmed polarity to a synchronised flag.
   function flag_polarity;
      input level;
      input invert;
      begin
         flag_polarity = level ^ invert;
      end
   endfunction

   assign dir_sel = direct_select(reg_addr);
   assign reg_hit = (dir_sel != DSEL_NONE);
   assign ind_wr  = reg_wr && (dir_sel == DSEL_ID);

   always @* begin
      format_config_next = format_config_reg;
      if (reg_wr && (dir_sel == DSEL_FMT)) begin
         format_config_next = reg_wdata;
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         format_config_reg <= `COCR_RST_VAL;
      end else begin
         format_config_reg <= format_config_next;
      end
   end

   // Data port accesses never move the pointer, so repeated ones hit one register.
   always @* begin
      indirect_address_next = indirect_address_reg;
      if (reg_wr && (dir_sel == DSEL_IA)) begin
         indirect_address_next = reg_wdata;
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         indirect_address_reg <= `COCR_RST_VAL;
      end else begin
         indirect_address_reg <= indirect_address_next;
      end
   end

   cocr_ind_regs cocr_ind_regs_inst (
      .core_clk  (core_clk),
      .rstn      (rstn),
      .ind_addr  (indirect_address_reg),
      .ind_wr    (ind_wr),
      .ind_wdata (reg_wdata),
      .ind_rdata (ind_rdata),
      .ind_flat  (ind_flat)
   );

   // Read data is registered: it stands from the edge after reg_rd until the next read.
   always @* begin
      rdata_next = reg_rdata;
      if (reg_rd) begin
         case (dir_sel)
            DSEL_FMT: begin
               rdata_next = format_config_reg;
            end
            DSEL_IA: begin
               rdata_next = indirect_address_reg;
            end
            DSEL_ID: begin
               rdata_next = ind_rdata;
            end
            default: begin
               rdata_next = 8'h00;
            end
         endcase
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= `COCR_RST_VAL;
      end else begin
         reg_rdata <= rdata_next;
      end
   end

   assign output_format_select = format_config_reg[`COCR_OUTPUT_FORMAT_SELECT_MSB:`COCR_OUTPUT_FORMAT_SELECT_LSB];
   assign input_format_select  = format_config_reg[`COCR_INPUT_FORMAT_SELECT_MSB:`COCR_INPUT_FORMAT_SELECT_LSB];
   // Codes above nine are undefined; flagged so downstream can hold off.
   assign output_format_valid  = (output_format_select <= `COCR_OUTPUT_FORMAT_SELECT_MAX);

   // The flags come from another clock domain, so each passes two flops first.
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         vs_meta_reg <= 1'b0;
         vs_sync_reg <= 1'b0;
      end else begin
         vs_meta_reg <= vertical_sync_in;
         vs_sync_reg <= vs_meta_reg;
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         av_meta_reg <= 1'b0;
         av_sync_reg <= 1'b0;
      end else begin
         av_meta_reg <= active_video_flag_in;
         av_sync_reg <= av_meta_reg;
      end
   end

   // Only the second stage feeds the polarity logic; downstream expects active high.
   always @* begin
      vs_next = flag_polarity(vs_sync_reg, format_config_reg[`COCR_VS_INV_BIT]);
   end

   always @* begin
      av_next = flag_polarity(av_sync_reg, format_config_reg[`COCR_AV_INV_BIT]);
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         vertical_sync     <= 1'b0;
         active_video_flag <= 1'b0;
      end else begin
         vertical_sync     <= vs_next;
         active_video_flag <= av_next;
      end
   end

   assign clk_prep_raw           = ind_byte(ind_flat, SLOT_CLK_PREP);
   assign clk_zero_raw           = ind_byte(ind_flat, SLOT_CLK_ZERO);
   assign clock_prepare_override = clk_prep_raw[`COCR_OVR_BIT];
   assign clock_zero_override    = clk_zero_raw[`COCR_OVR_BIT];

   // No timing derivation exists here; the AUTO parameters stand in for it, so
   // whoever integrates the block must set them to suit the lane rate.
   always @* begin
      clock_prepare_next = AUTO_CLK_PREP;
      if (clock_prepare_override) begin
         clock_prepare_next = clk_prep_raw[`COCR_CLK_PREP_MSB:0];
      end
   end

   always @* begin
      clock_zero_next = AUTO_CLK_ZERO;
      if (clock_zero_override) begin
         clock_zero_next = clk_zero_raw[`COCR_CLK_ZERO_MSB:0];
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         clock_prepare_value <= 5'h00;
      end else begin
         clock_prepare_value <= clock_prepare_next;
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         clock_zero_value <= 6'h00;
      end else begin
         clock_zero_value <= clock_zero_next;
      end
   end

   // Undefined indirect offsets are not stored, so a stray write is harmless.
   assign clock_trail_time           = ind_byte(ind_flat, SLOT_CLK_TRAIL);
   assign clock_post_time            = ind_byte(ind_flat, SLOT_CLK_POST);
   assign hs_prepare_time            = ind_byte(ind_flat, SLOT_HS_PREP);
   assign hs_zero_time               = ind_byte(ind_flat, SLOT_HS_ZERO);
   assign hs_trail_time              = ind_byte(ind_flat, SLOT_HS_TRAIL);
   assign hs_exit_time               = ind_byte(ind_flat, SLOT_HS_EXIT);
   assign lp_period_time             = ind_byte(ind_flat, SLOT_LP_PERIOD);
   assign raw_alignment              = ind_byte(ind_flat, SLOT_RAW_ALIGN);
   assign output_port0_enable        = ind_byte(ind_flat, SLOT_PORT0_EN);
   assign output_port1_enable        = ind_byte(ind_flat, SLOT_PORT1_EN);
   assign passthrough_control_field  = ind_byte(ind_flat, SLOT_PASSTHRU);
   assign virtual_channel_identifier = ind_byte(ind_flat, SLOT_VC_ID);

endmodule
`default_nettype wire

// file: bench/cocr_csi_cfg_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cocr_csi_cfg_monitor #(
   parameter [4:0] AUTO_CLK_PREP = 5'h06,
   parameter [5:0] AUTO_CLK_ZERO = 6'h14
) (
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       rstn,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_hit,
   // Video flags
   input wire logic       vertical_sync_in,
   input wire logic       active_video_flag_in,
   input wire logic       vertical_sync,
   input wire logic       active_video_flag,
   // Configuration outputs
   input wire logic [3:0] output_format_select,
   input wire logic [1:0] input_format_select,
   input wire logic       output_format_valid,
   input wire logic [4:0] clock_prepare_value,
   input wire logic [5:0] clock_zero_value,
   input wire logic       clock_prepare_override,
   input wire logic       clock_zero_override
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // The invert bits are not at the ports, so they are rebuilt from observed writes.
   logic [1:0] inv_reg;
   wire        fmt_wr;
   assign fmt_wr = reg_wr && reg_addr == 8'h6b;
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         inv_reg <= 2'h0;
      else if (fmt_wr)
         inv_reg <= reg_wdata[1:0];
   end
   // A window of four steady cycles covers the two-flop synchroniser and the output flop.
   sequence vs_steady;
      ($stable(vertical_sync_in) && $stable(inv_reg[1])) [*4];
   endsequence
   sequence av_steady;
      ($stable(active_video_flag_in) && $stable(inv_reg[0])) [*4];
   endsequence
   fmt_write_a: assert property (fmt_wr |=>
      {output_format_select, input_format_select} == $past(reg_wdata[7:2]))
      else $error("format fields differ from written value");
   fmt_valid_a: assert property (output_format_valid == (output_format_select <= 4'h9))
      else $error("format valid flag wrong");
   prep_auto_a: assert property (!clock_prepare_override |=>
      clock_prepare_value == AUTO_CLK_PREP) else $error("prepare value not automatic");
   zero_auto_a: assert property (!clock_zero_override |=>
      clock_zero_value == AUTO_CLK_ZERO) else $error("zero value not automatic");
   miss_read_a: assert property (reg_rd && !reg_hit |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   hit_decode_a: assert property (reg_hit == (reg_addr inside {8'h6b, 8'h6c, 8'h6d}))
      else $error("address hit decode wrong");
   vs_invert_a: assert property (vs_steady |->
      vertical_sync == (vertical_sync_in ^ inv_reg[1])) else $error("vertical sync wrong");
   av_invert_a: assert property (av_steady |->
      active_video_flag == (active_video_flag_in ^ inv_reg[0])) else $error("active video wrong");
endmodule
bind cocr_csi_cfg cocr_csi_cfg_monitor #(.AUTO_CLK_PREP(AUTO_CLK_PREP),
   .AUTO_CLK_ZERO(AUTO_CLK_ZERO)) cocr_csi_cfg_monitor_inst (.core_clk, .rstn, .reg_addr,
   .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_hit, .vertical_sync_in, .active_video_flag_in,
   .vertical_sync, .active_video_flag, .output_format_select, .input_format_select,
   .output_format_valid, .clock_prepare_value, .clock_zero_value, .clock_prepare_override,
   .clock_zero_override);
`default_nettype wire

// file: bench/cocr_csi_cfg_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cocr_csi_cfg_tb;
   // Automatic values differ from the defaults so a hard-wired constant shows up.
   localparam logic [4:0] PREP = 5'h0b;
   localparam logic [5:0] ZERO = 6'h27;
   logic       core_clk = 1'b0;
   logic       rstn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic       vs_in = 1'b0;
   logic       av_in = 1'b0;
   wire  [7:0] rdata;
   wire  [7:0] tv [2:13];
   wire  [3:0] ofs;
   wire  [1:0] ifs;
   wire  [4:0] pv;
   wire  [5:0] zv;
   wire        hit, vs, av, ofv, po, zo;
   int         err_total = 0;
   int         n_checks = 0;
   int         cycles = 0;
   int         i;
   logic [7:0] offs [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
                             8'h09, 8'h13, 8'h14, 8'h16, 8'h2e};
   cocr_csi_cfg #(.AUTO_CLK_PREP(PREP), .AUTO_CLK_ZERO(ZERO)) cocr_csi_cfg_inst (
      .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(rdata), .reg_hit(hit), .vertical_sync_in(vs_in),
      .active_video_flag_in(av_in), .vertical_sync(vs), .active_video_flag(av),
      .output_format_select(ofs), .input_format_select(ifs), .output_format_valid(ofv),
      .clock_prepare_value(pv), .clock_zero_value(zv), .clock_prepare_override(po),
      .clock_zero_override(zo), .clock_trail_time(tv[2]), .clock_post_time(tv[3]),
      .hs_prepare_time(tv[4]), .hs_zero_time(tv[5]), .hs_trail_time(tv[6]),
      .hs_exit_time(tv[7]), .lp_period_time(tv[8]), .raw_alignment(tv[9]),
      .output_port0_enable(tv[10]), .output_port1_enable(tv[11]),
      .passthrough_control_field(tv[12]), .virtual_channel_identifier(tv[13]));
   function automatic logic [7:0] dv(input logic [7:0] o);
      return 8'h80 | (o ^ 8'h2a);
   endfunction
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk) #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge core_clk) #1;
      reg_wr = 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk) #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge core_clk) #1;
      reg_rd = 1'b0;
      check(rdata, exp);
   endtask
   initial begin
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 2000) begin
         err_total++;
         finish_test();
      end
   end
   initial begin
      repeat (12) @(posedge core_clk);
      #1 rstn = 1'b1;
      @(posedge core_clk) #1;
      check(pv, PREP);
      check(zv, ZERO);
      rdc(8'h6b, 8'h00);
      rdc(8'h6c, 8'h00);
      rdc(8'h6d, 8'h00);
      $display("test reset done");
      for (i = 0; i < 16; i++) begin
         wr(8'h6b, {i[3:0], i[1:0], 2'h0});
         check(ofs, i[3:0]);
         check(ifs, i[1:0]);
         check(ofv, i <= 9);
         rdc(8'h6b, {i[3:0], i[1:0], 2'h0});
      end
      $display("test format done");
      vs_in = 1'b1;
      wr(8'h6b, 8'h02);
      repeat (4) @(posedge core_clk) #1;
      check(vs, 8'h00);
      check(av, 8'h00);
      wr(8'h6b, 8'h01);
      repeat (4) @(posedge core_clk) #1;
      check(vs, 8'h01);
      check(av, 8'h01);
      $display("test invert done");
      foreach (offs[k]) begin
         wr(8'h6c, offs[k]);
         wr(8'h6d, dv(offs[k]));
      end
      foreach (offs[k]) begin
         wr(8'h6c, offs[k]);
         rdc(8'h6d, dv(offs[k]));
         rdc(8'h6d, dv(offs[k]));
         rdc(8'h6c, offs[k]);
         if (k >= 2) check(tv[k], dv(offs[k]));
      end
      check(po, 8'h01);
      check(pv, 8'h0a);
      check(zo, 8'h01);
      check(zv, 8'h2b);
      check(tv[13], 8'h84);
      wr(8'h6c, 8'h0a);
      wr(8'h6d, 8'hff);
      rdc(8'h6d, 8'h00);
      wr(8'h6e, 8'h5a);
      rdc(8'h6e, 8'h00);
      rdc(8'h6c, 8'h0a);
      wr(8'h6c, 8'h00);
      wr(8'h6d, 8'h15);
      @(posedge core_clk) #1;
      check(pv, PREP);
      $display("test indirect done");
      finish_test();
   end
endmodule
`default_nettype wire
